/* File: adc_alert_defines.vh */
// Operation
// - noise-delay bit holds sampling during bus activity
// - noise-delay bit cleared after power-up
// - conversion time may stretch under bus activity
// - bus-line pulses under 50 ns ignored
// - voltage result: 16-bit read-only straight binary
// - two-byte read, high byte first
// - top nibble tag, low twelve bits result
// - tags 0-7 inputs, 8 temperature, 9 average
// - temperature results stored twos complement
// - temperature result refreshed about every 5 ms
// - average register updated per temperature conversion
// - first average equals first raw temperature
// - nine limit pairs, twelve bits, top zero
// - one hysteresis register per limit pair
// - voltage limits reset full scale and zero
// - temperature limits reset 0x07FF and 0x0800
// - result above upper limit raises alert
// - upper alert releases N below limit
// - result below lower limit raises alert
// - lower alert releases N above limit
// - clear-alert command bit resets alert output
// - hysteresis registers reset to zero
// - polarity bit one gives active-low alert
// - sticky upper and lower status per channel
// - clear-alert bit clears alert status registers
`ifndef ADC_ALERT_DEFINES_VH
`define ADC_ALERT_DEFINES_VH

// register pointers
`define REG_COMMAND        6'h00
`define REG_VOLT_RESULT    6'h01
`define REG_TEMP_RESULT    6'h02
`define REG_AVG_RESULT     6'h03
`define REG_LIMIT_BASE     6'h04
`define REG_LIMIT_STRIDE   6'h03
`define REG_STATUS_VOLT    6'h1F
`define REG_STATUS_TEMP    6'h20

// command register fields
`define CMD_TEMP_SEL_BIT   7
`define CMD_NOISE_BIT      5
`define CMD_POLARITY_BIT   3
`define CMD_CLEAR_BIT      2
`define CMD_SOFT_RST_BIT   1
`define CMD_RESET          16'h0000

// source tags
`define TAG_TEMP           4'h8
`define TAG_AVG            4'h9

// limit reset values
`define VOLT_HIGH_RESET    12'hFFF
`define VOLT_LOW_RESET     12'h000
`define TEMP_HIGH_RESET    12'h7FF
`define TEMP_LOW_RESET     12'h800
`define HYST_RESET         12'h000
`define TEMP_SIGN_FLIP     12'h800

// timing
`define CLK_NS             20
`define GLITCH_NS          50
// one sample more than the limit spans: three samples cover only 40 ns
`define GLITCH_CYC         ((`GLITCH_NS + `CLK_NS - 1) / `CLK_NS + 1)
`define QUIET_NS           200
`define QUIET_CYC          ((`QUIET_NS + `CLK_NS - 1) / `CLK_NS)
`define TEMP_PERIOD_US     5000
`define TEMP_PERIOD_CYC    ((`TEMP_PERIOD_US * 1000) / `CLK_NS)
`define AVG_SHIFT          3

`endif

/* File: adc_result_alert.v */
`include "adc_alert_defines.vh"

// result registers, limit checking and alert pin of the converter
module adc_result_alert #(
    parameter TEMP_PERIOD = `TEMP_PERIOD_CYC,
    parameter NUM_CH      = 8
) (
    // clock and reset
    input  wire        CLK,
    input  wire        RST,
    // register access from the serial protocol engine
    input  wire [5:0]  REG_ADDR,
    input  wire        REG_ADDR_LOAD,
    input  wire        REG_WR_BYTE,
    input  wire [7:0]  REG_WDATA,
    input  wire        REG_RD_BYTE,
    output reg  [7:0]  REG_RDATA,
    output reg         REG_RD_VALID,
    // raw bus lines, watched for activity
    input  wire        SCL_IN,
    input  wire        SDA_IN,
    // converter core
    input  wire        CONV_DONE,
    input  wire [3:0]  CONV_TAG,
    input  wire [11:0] CONV_DATA,
    output reg         CONV_HOLD,
    output reg         TEMP_REQ,
    // alert pin
    output reg         ALERT
);

    localparam NSRC = NUM_CH + 2;   // inputs, temperature, average
    localparam [31:0] QUIET_LOAD = `QUIET_CYC;   // quiet window reload, cut to counter width below
    // register file
    reg  [15:0] cmd_q;                   // command register
    reg  [15:0] volt_q;                  // latest voltage result
    reg  [15:0] temp_q;                  // latest temperature result
    reg  [11:0] avg_q;                   // running temperature average
    reg         avg_seed_q;              // average holds history
    reg  [11:0] hi_q [0:NUM_CH];         // upper limits
    reg  [11:0] lo_q [0:NUM_CH];         // lower limits
    reg  [11:0] hy_q [0:NUM_CH];         // hysteresis margins
    reg  [NSRC-1:0] hi_st_q;             // sticky upper violations
    reg  [NSRC-1:0] lo_st_q;             // sticky lower violations
    reg  [NSRC-1:0] hi_act_q;            // upper alert still holding
    reg  [NSRC-1:0] lo_act_q;            // lower alert still holding
    reg  [NSRC-1:0] upd_q;               // one-cycle compare strobe per source

    // byte sequencing
    reg  [5:0]  ptr_q;                   // register pointer
    reg         wr_phase_q;              // high byte already taken
    reg  [7:0]  wr_hi_q;                 // held high write byte
    reg         rd_phase_q;              // high byte already returned
    reg  [7:0]  rd_lo_q;                 // low byte snapshot
    reg         soft_q;                  // soft reset pulse
    wire        srst = RST | soft_q;     // hard or command reset

    // bus line synchronisers and filters
    reg  [1:0]  scl_sync_q;
    reg  [1:0]  sda_sync_q;
    wire        scl_f;
    wire        sda_f;
    reg         scl_f_q;
    reg         sda_f_q;
    reg  [7:0]  quiet_q;                 // cycles left before bus is quiet

    // temperature scheduling
    reg  [31:0] tmr_q;

    wire        wr_commit = REG_WR_BYTE & wr_phase_q;
    wire [15:0] wr_word   = {wr_hi_q, REG_WDATA};
    wire        clr_alert = cmd_q[`CMD_CLEAR_BIT];

    // two flops on each pin before anything looks at it
    always @(posedge CLK)
    begin
        if (RST)
        begin
            scl_sync_q <= 2'h3;
            sda_sync_q <= 2'h3;
        end
        else
        begin
            scl_sync_q <= {scl_sync_q[0], SCL_IN};
            sda_sync_q <= {sda_sync_q[0], SDA_IN};
        end
    end

    glitch_reject #(.STABLE_CYC(`GLITCH_CYC)) u_scl_filt (
        .clk  (CLK),
        .rst  (RST),
        .din  (scl_sync_q[1]),
        .dout (scl_f)
    );

    glitch_reject #(.STABLE_CYC(`GLITCH_CYC)) u_sda_filt (
        .clk  (CLK),
        .rst  (RST),
        .din  (sda_sync_q[1]),
        .dout (sda_f)
    );

    // activity window: any filtered edge restarts the quiet count
    always @(posedge CLK)
    begin
        if (RST)
        begin
            scl_f_q   <= 1'b1;
            sda_f_q   <= 1'b1;
            quiet_q   <= 8'h00;
            CONV_HOLD <= 1'b0;
        end
        else
        begin
            scl_f_q <= scl_f;
            sda_f_q <= sda_f;
            if ((scl_f ^ scl_f_q) | (sda_f ^ sda_f_q))
                quiet_q <= QUIET_LOAD[7:0];
            else if (quiet_q != 8'h00)
                quiet_q <= quiet_q - 8'h01;
            // core stalls its trials while held, so conversions may lengthen
            CONV_HOLD <= cmd_q[`CMD_NOISE_BIT] &
                         (((scl_f ^ scl_f_q) | (sda_f ^ sda_f_q)) | (quiet_q != 8'h00));
        end
    end

    // temperature conversion request, one pulse per period
    always @(posedge CLK)
    begin
        if (srst)
        begin
            tmr_q    <= 32'h0;
            TEMP_REQ <= 1'b0;
        end
        else if (tmr_q == TEMP_PERIOD - 1)
        begin
            tmr_q    <= 32'h0;
            TEMP_REQ <= 1'b1;
        end
        else
        begin
            tmr_q    <= tmr_q + 32'h1;
            TEMP_REQ <= 1'b0;
        end
    end

    // command register and byte-wise write sequencing
    always @(posedge CLK)
    begin
        if (srst)
        begin
            cmd_q      <= `CMD_RESET;
            ptr_q      <= 6'h00;
            wr_phase_q <= 1'b0;
            wr_hi_q    <= 8'h00;
            soft_q     <= 1'b0;
        end
        else
        begin
            soft_q <= 1'b0;
            if (REG_ADDR_LOAD)
            begin
                ptr_q      <= REG_ADDR;
                wr_phase_q <= 1'b0;
            end
            else if (REG_WR_BYTE)
            begin
                wr_phase_q <= ~wr_phase_q;
                if (!wr_phase_q)
                    wr_hi_q <= REG_WDATA;
            end
            // the whole word lands only when its low byte arrives
            if (wr_commit && ptr_q == `REG_COMMAND)
            begin
                cmd_q  <= wr_word;
                soft_q <= wr_word[`CMD_SOFT_RST_BIT];
            end
        end
    end

    // result registers and temperature average
    always @(posedge CLK)
    begin : results
        reg signed [12:0] diff;
        diff = $signed({CONV_DATA[11], CONV_DATA}) - $signed({avg_q[11], avg_q});
        if (srst)
        begin
            volt_q     <= 16'h0000;
            temp_q     <= {`TAG_TEMP, 12'h000};
            avg_q      <= 12'h000;
            avg_seed_q <= 1'b0;
            upd_q      <= {NSRC{1'b0}};
        end
        else
        begin
            upd_q <= {NSRC{1'b0}};
            if (!cmd_q[`CMD_TEMP_SEL_BIT])
                avg_seed_q <= 1'b0;       // averaging off: history dropped
            if (CONV_DONE && CONV_TAG < NUM_CH)
            begin
                volt_q <= {CONV_TAG, CONV_DATA};
                upd_q[CONV_TAG] <= 1'b1;
            end
            else if (CONV_DONE && CONV_TAG == `TAG_TEMP)
            begin
                temp_q <= {`TAG_TEMP, CONV_DATA};
                upd_q[NUM_CH]   <= 1'b1;
                upd_q[NUM_CH+1] <= 1'b1;
                if (!avg_seed_q || !cmd_q[`CMD_TEMP_SEL_BIT])
                begin
                    avg_q      <= CONV_DATA;
                    avg_seed_q <= cmd_q[`CMD_TEMP_SEL_BIT];
                end
                else
                begin
                    // first-order filter; arithmetic shift keeps the sign
                    avg_q <= avg_q + {{(`AVG_SHIFT-1){diff[12]}}, diff[12:`AVG_SHIFT]};
                end
            end
        end
    end

    // per-channel limit registers and alert state
    genvar i;
    generate
        for (i = 0; i < NSRC; i = i + 1)
        begin : g_src
            localparam LIM  = (i > NUM_CH) ? NUM_CH : i;  // average shares temp limits
            localparam TMP  = (i >= NUM_CH);
            wire [11:0] flip = TMP ? `TEMP_SIGN_FLIP : 12'h000;
            wire [11:0] val  = (i == NUM_CH + 1) ? avg_q :
                               (i == NUM_CH) ? temp_q[11:0] : volt_q[11:0];
            // offset binary lets one unsigned compare serve both formats
            wire [12:0] r    = {1'b0, val ^ flip};
            wire [12:0] h    = {1'b0, hi_q[LIM] ^ flip};
            wire [12:0] l    = {1'b0, lo_q[LIM] ^ flip};
            wire [12:0] n    = {1'b0, hy_q[LIM]};
            wire        over  = r > h;
            wire        under = r < l;
            wire        hrel  = (r + n) <= h;
            wire        lrel  = r >= (l + n);

            if (i <= NUM_CH)
            begin : g_lim
                localparam [31:0] BASE = `REG_LIMIT_BASE + i * `REG_LIMIT_STRIDE;
                // limits and margin, twelve bits held, top nibble reads zero
                always @(posedge CLK)
                begin
                    if (srst)
                    begin
                        hi_q[i] <= TMP ? `TEMP_HIGH_RESET : `VOLT_HIGH_RESET;
                        lo_q[i] <= TMP ? `TEMP_LOW_RESET : `VOLT_LOW_RESET;
                        hy_q[i] <= `HYST_RESET;
                    end
                    else if (wr_commit)
                    begin
                        if (ptr_q == BASE[5:0])
                            hi_q[i] <= wr_word[11:0];
                        if (ptr_q == BASE[5:0] + 6'h01)
                            lo_q[i] <= wr_word[11:0];
                        if (ptr_q == BASE[5:0] + 6'h02)
                            hy_q[i] <= wr_word[11:0];
                    end
                end
            end

            // alert holds until hysteresis release or a clear command
            always @(posedge CLK)
            begin
                if (srst || clr_alert)
                begin
                    hi_act_q[i] <= 1'b0;
                    lo_act_q[i] <= 1'b0;
                    hi_st_q[i]  <= 1'b0;
                    lo_st_q[i]  <= 1'b0;
                end
                else if (upd_q[i])
                begin
                    if (over)
                        hi_act_q[i] <= 1'b1;
                    else if (hrel)
                        hi_act_q[i] <= 1'b0;
                    if (under)
                        lo_act_q[i] <= 1'b1;
                    else if (lrel)
                        lo_act_q[i] <= 1'b0;
                    if (over)
                        hi_st_q[i] <= 1'b1;
                    if (under)
                        lo_st_q[i] <= 1'b1;
                end
            end
        end
    endgenerate

    // alert pin, sense chosen by the polarity bit
    always @(posedge CLK)
    begin
        if (srst)
            ALERT <= 1'b0;
        else
            ALERT <= (|(hi_act_q | lo_act_q)) ^ cmd_q[`CMD_POLARITY_BIT];
    end

    // word visible at the pointer
    reg [15:0] rd_word;
    integer k;
    always @*
    begin
        rd_word = 16'h0000;
        case (ptr_q)
            `REG_COMMAND:     rd_word = cmd_q;
            `REG_VOLT_RESULT: rd_word = volt_q;
            `REG_TEMP_RESULT: rd_word = temp_q;
            `REG_AVG_RESULT:  rd_word = {`TAG_AVG, avg_q};
            `REG_STATUS_VOLT:
            begin
                for (k = 0; k < NUM_CH; k = k + 1)
                begin
                    rd_word[2*k]   = lo_st_q[k];
                    rd_word[2*k+1] = hi_st_q[k];
                end
            end
            `REG_STATUS_TEMP:
                rd_word = {12'h000, hi_st_q[NUM_CH+1], lo_st_q[NUM_CH+1],
                           hi_st_q[NUM_CH], lo_st_q[NUM_CH]};
            default:
            begin
                for (k = 0; k <= NUM_CH; k = k + 1)
                begin
                    if (ptr_q == `REG_LIMIT_BASE + k * `REG_LIMIT_STRIDE)
                        rd_word = {4'h0, hi_q[k]};
                    if (ptr_q == `REG_LIMIT_BASE + k * `REG_LIMIT_STRIDE + 1)
                        rd_word = {4'h0, lo_q[k]};
                    if (ptr_q == `REG_LIMIT_BASE + k * `REG_LIMIT_STRIDE + 2)
                        rd_word = {4'h0, hy_q[k]};
                end
            end
        endcase
    end

    // byte reads: high byte first, low byte from the same snapshot
    always @(posedge CLK)
    begin
        if (srst)
        begin
            REG_RDATA    <= 8'h00;
            REG_RD_VALID <= 1'b0;
            rd_phase_q   <= 1'b0;
            rd_lo_q      <= 8'h00;
        end
        else
        begin
            REG_RD_VALID <= REG_RD_BYTE & ~REG_ADDR_LOAD;   // a reload drops the byte
            if (REG_ADDR_LOAD)
                rd_phase_q <= 1'b0;
            else if (REG_RD_BYTE)
            begin
                rd_phase_q <= ~rd_phase_q;
                if (!rd_phase_q)
                begin
                    REG_RDATA <= rd_word[15:8];
                    rd_lo_q   <= rd_word[7:0];
                end
                else
                    REG_RDATA <= rd_lo_q;
            end
        end
    end

endmodule // adc_result_alert

/* File: adc_result_alert_props.sv */
// port-level checks on the result and alert block
module adc_result_alert_props #(
    parameter TEMP_PERIOD = 250000,
    parameter NUM_CH      = 8
) (
    // clock and reset
    input logic        CLK,
    input logic        RST,
    // register access
    input logic [5:0]  REG_ADDR,
    input logic        REG_ADDR_LOAD,
    input logic        REG_WR_BYTE,
    input logic [7:0]  REG_WDATA,
    input logic        REG_RD_BYTE,
    input logic [7:0]  REG_RDATA,
    input logic        REG_RD_VALID,
    // bus lines
    input logic        SCL_IN,
    input logic        SDA_IN,
    // converter core and alert
    input logic        CONV_DONE,
    input logic [3:0]  CONV_TAG,
    input logic [11:0] CONV_DATA,
    input logic        CONV_HOLD,
    input logic        TEMP_REQ,
    input logic        ALERT
);
    timeunit 1ns;
    timeprecision 100ps;
    logic        scl_q;    // lines one edge ago
    logic        sda_q;
    logic [7:0]  quiet_q;  // edges since a raw line moved, saturating
    logic [7:0]  ev_q;     // edges since a result or a write byte
    logic [31:0] gap_q;    // edges since the last temperature request
    logic        seen_q;   // a first request has been seen

    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);

    // helper counters; the 8-bit ones saturate so long idle spells cannot wrap
    always_ff @(posedge CLK)
    begin
        scl_q <= SCL_IN;
        sda_q <= SDA_IN;
        if (RST)
        begin
            quiet_q <= 8'h00;
            ev_q    <= 8'h00;
            gap_q   <= 32'h0;
            seen_q  <= 1'b0;
        end
        else
        begin
            quiet_q <= (SCL_IN != scl_q || SDA_IN != sda_q) ? 8'h00
                     : (quiet_q == 8'hFF ? quiet_q : quiet_q + 8'h01);
            ev_q    <= (CONV_DONE || REG_WR_BYTE) ? 8'h00
                     : (ev_q == 8'hFF ? ev_q : ev_q + 8'h01);
            gap_q   <= TEMP_REQ ? 32'h1 : gap_q + 32'h1;
            seen_q  <= seen_q | TEMP_REQ;
        end
    end

    chk_rd_answer: assert property (REG_RD_BYTE && !REG_ADDR_LOAD |=> REG_RD_VALID)
        else $error("read byte not answered next cycle");
    chk_rd_cause: assert property (REG_RD_VALID |-> $past(REG_RD_BYTE) && !$past(REG_ADDR_LOAD))
        else $error("read valid without a read request");
    chk_rdata_stands: assert property (!REG_RD_VALID && ev_q > 8'h03 |-> $stable(REG_RDATA))
        else $error("read data moved without a read");
    chk_reset_idle: assert property (disable iff (1'b0) RST |=> !CONV_HOLD && !ALERT && !TEMP_REQ)
        else $error("outputs not idle after reset");
    chk_temp_once: assert property (TEMP_REQ |=> !TEMP_REQ)
        else $error("temperature request longer than one cycle");
    chk_temp_period: assert property (TEMP_REQ && seen_q |-> gap_q == TEMP_PERIOD)
        else $error("temperature request spacing wrong");
    chk_hold_cause: assert property (CONV_HOLD |-> quiet_q <= 8'd20)
        else $error("hold without recent bus activity");
    chk_hold_release: assert property ($fell(CONV_HOLD) |-> quiet_q >= 8'd10)
        else $error("hold dropped before the quiet window");
    chk_alert_cause: assert property ($changed(ALERT) |-> ev_q <= 8'd4)
        else $error("alert moved without a result or write");
endmodule // adc_result_alert_props

bind adc_result_alert adc_result_alert_props #(
    .TEMP_PERIOD(TEMP_PERIOD),
    .NUM_CH(NUM_CH)
) i_props (.*);

/* File: adc_result_alert_tb.sv */
// register-level bench: reads, writes and converter results with expected values
module adc_result_alert_tb;
    timeunit 1ns;
    timeprecision 100ps;

    localparam int TP = 200;  // shortened temperature period
    logic        clk, rst, ld, wr, rd, done, hold_seen, hold_clr;
    logic [5:0]  addr;
    logic [7:0]  wdata;
    logic [3:0]  tag;
    logic [11:0] data;
    logic [15:0] got;
    wire  [7:0]  rdata;
    wire         rvalid, hold, treq, alert, scl, sda;
    int          n_fail, samples_checked, k;

    adc_result_alert #(.TEMP_PERIOD(TP)) i_dut (
        .CLK(clk), .RST(rst), .REG_ADDR(addr), .REG_ADDR_LOAD(ld),
        .REG_WR_BYTE(wr), .REG_WDATA(wdata), .REG_RD_BYTE(rd),
        .REG_RDATA(rdata), .REG_RD_VALID(rvalid), .SCL_IN(scl), .SDA_IN(sda),
        .CONV_DONE(done), .CONV_TAG(tag), .CONV_DATA(data),
        .CONV_HOLD(hold), .TEMP_REQ(treq), .ALERT(alert)
    );
    bus_lines_model i_bus (.SCL(scl), .SDA(sda));

    // 50 MHz clock
    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // remembers any hold pulse, even one between checks; hold_clr forgets it
    always @(posedge clk)
        if (hold_clr)
            hold_seen <= 1'b0;
        else if (hold === 1'b1)
            hold_seen <= 1'b1;

    // forgets earlier hold pulses; returns off the edge so the lines never move on it
    task automatic clr_seen();
        @(posedge clk);
        hold_clr <= 1'b1;
        @(posedge clk);
        hold_clr <= 1'b0;
        #1;
    endtask

    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        samples_checked++;
        if (g !== e)
        begin
            n_fail++;
            $display("BAD %0t got %h want %h", $time, g, e);
        end
    endtask

    task automatic alert_is(input logic e);
        chk({15'h0, alert}, {15'h0, e});
    endtask

    task automatic end_sim();
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // bounded wait for hold (sel 0) or temperature request (sel 1)
    task automatic wait_sig(input bit sel, input logic lvl, input int lim);
        int i;
        for (i = 0; i < lim && (sel ? treq : hold) !== lvl; i++)
            @(posedge clk);
        chk({15'h0, sel ? treq : hold}, {15'h0, lvl});
        if ((sel ? treq : hold) !== lvl)
            end_sim();
    endtask

    // pointer load, then both bytes back to back, high byte first
    task automatic rd16(input logic [5:0] a, output logic [15:0] v);
        logic ok;
        @(posedge clk);
        ld   <= 1'b1;
        addr <= a;
        @(posedge clk);
        ld <= 1'b0;
        rd <= 1'b1;
        @(posedge clk);
        #1;
        ok       = rvalid;
        v[15:8]  = rdata;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        v[7:0] = rdata;
        chk({14'h0, ok, rvalid}, 16'h0003);
    endtask

    // writes settle a few cycles so alert effects have landed
    task automatic wr16(input logic [5:0] a, input logic [15:0] v);
        @(posedge clk);
        ld   <= 1'b1;
        addr <= a;
        @(posedge clk);
        ld    <= 1'b0;
        wr    <= 1'b1;
        wdata <= v[15:8];
        @(posedge clk);
        wdata <= v[7:0];
        @(posedge clk);
        wr <= 1'b0;
        repeat (3) @(posedge clk);
        #1;
    endtask

    // one result from the core; pin is due two cycles after it is taken
    task automatic conv(input logic [3:0] t, input logic [11:0] d);
        @(posedge clk);
        done <= 1'b1;
        tag  <= t;
        data <= d;
        @(posedge clk);
        done <= 1'b0;
        repeat (3) @(posedge clk);
        #1;
    endtask

    initial
    begin
        {rst, ld, wr, rd, done, hold_clr} = 6'b100001;
        {addr, wdata, tag, data} = 30'h0;
        n_fail = 0;
        samples_checked = 0;
        repeat (5) @(posedge clk);
        rst      <= 1'b0;
        hold_clr <= 1'b0;
        // limit and hysteresis defaults, nine channels
        for (k = 0; k < 9; k++)
        begin
            rd16(6'h04 + 6'(3 * k), got);
            chk(got, k == 8 ? 16'h07FF : 16'h0FFF);
            rd16(6'h05 + 6'(3 * k), got);
            chk(got, k == 8 ? 16'h0800 : 16'h0000);
            rd16(6'h06 + 6'(3 * k), got);
            chk(got, 16'h0000);
        end
        rd16(6'h00, got);
        chk(got, 16'h0000);
        rd16(6'h3F, got);
        chk(got, 16'h0000);
        wr16(6'h07, 16'hFABC);
        rd16(6'h07, got);
        chk(got, 16'h0ABC);
        // every input tag lands in the voltage result
        for (k = 0; k < 8; k++)
        begin
            conv(4'(k), 12'h100 + 12'(k));
            rd16(6'h01, got);
            chk(got, {4'(k), 12'h100 + 12'(k)});
        end
        conv(4'hA, 12'h555);
        rd16(6'h01, got);
        chk(got, 16'h7107);
        wr16(6'h01, 16'h1234);
        rd16(6'h01, got);
        chk(got, 16'h7107);
        // channel zero: upper 0x800, lower 0x100, margin 0x10
        wr16(6'h04, 16'h0800);
        wr16(6'h05, 16'h0100);
        wr16(6'h06, 16'h0010);
        conv(4'h0, 12'h800);
        alert_is(1'b0);
        conv(4'h0, 12'h801);
        alert_is(1'b1);
        conv(4'h0, 12'h7F5);
        alert_is(1'b1);
        conv(4'h0, 12'h7F0);
        alert_is(1'b0);
        conv(4'h0, 12'h0FF);
        alert_is(1'b1);
        conv(4'h0, 12'h10F);
        alert_is(1'b1);
        conv(4'h0, 12'h110);
        alert_is(1'b0);
        rd16(6'h1F, got);
        chk(got, 16'h0003);
        conv(4'h0, 12'h900);
        wr16(6'h00, 16'h0004);
        alert_is(1'b0);
        rd16(6'h1F, got);
        chk(got, 16'h0000);
        wr16(6'h00, 16'h0008);
        alert_is(1'b1);
        conv(4'h0, 12'h900);
        alert_is(1'b0);
        conv(4'h0, 12'h400);
        alert_is(1'b1);
        wr16(6'h00, 16'h0000);
        // temperature, raw and averaged
        wait_sig(1'b1, 1'b1, TP + 10);
        conv(4'h8, 12'hF00);
        rd16(6'h02, got);
        chk(got, 16'h8F00);
        wr16(6'h00, 16'h0080);
        conv(4'h8, 12'h010);
        rd16(6'h03, got);
        chk(got, 16'h9010);
        conv(4'h8, 12'h090);
        rd16(6'h03, got);
        chk(got, 16'h9020);
        // temperature upper limit 0x100: a negative reading must stay inside it
        wr16(6'h1C, 16'h0100);
        conv(4'h8, 12'hF00);
        alert_is(1'b0);
        conv(4'h8, 12'h200);
        alert_is(1'b1);
        rd16(6'h20, got);
        chk(got, 16'h0002);
        // bus activity with the delay option off, then on
        clr_seen();
        i_bus.frame(8);
        repeat (20) @(posedge clk);
        chk({15'h0, hold_seen}, 16'h0000);
        wr16(6'h00, 16'h00A0);
        fork
            i_bus.frame(8);
            wait_sig(1'b0, 1'b1, 60);
        join
        wait_sig(1'b0, 1'b0, 40);
        clr_seen();
        i_bus.glitch();
        repeat (20) @(posedge clk);
        chk({15'h0, hold_seen}, 16'h0000);
        end_sim();
    end
endmodule // adc_result_alert_tb

/* File: bus_lines_model.sv */
// behavioural two-wire master: only makes line activity for the hold logic
module bus_lines_model (
    // open-drain lines, pulled up when released
    output logic SCL,
    output logic SDA
);
    timeunit 1ns;
    timeprecision 100ps;

    // released lines sit at the pull-up level
    initial
    begin
        SCL = 1'b1;
        SDA = 1'b1;
    end

    // one frame: start, nbits data bits, stop; 160 ns link clock only inside it
    task automatic frame(input int nbits);
        int i;
        SDA = 1'b0;
        #40;
        for (i = 0; i < nbits; i++)
        begin
            SCL = 1'b0;
            #40;
            SDA = i[0];
            #40;
            SCL = 1'b1;
            #80;
        end
        SCL = 1'b0;
        #40;
        SDA = 1'b0;
        #40;
        SCL = 1'b1;
        #40;
        SDA = 1'b1;
    endtask

    // a 20 ns dip: short enough that the device must not see it
    task automatic glitch();
        #5;
        SDA = 1'b0;
        #20;
        SDA = 1'b1;
    endtask
endmodule // bus_lines_model

/* File: glitch_reject.v */
`include "adc_alert_defines.vh"

// passes a synchronised line through only once it has held steady
module glitch_reject #(
    parameter STABLE_CYC = `GLITCH_CYC
) (
    // clock and reset
    input  wire clk,
    input  wire rst,
    // line in and filtered line out
    input  wire din,
    output reg  dout
);

    reg [3:0] cnt_q;   // cycles the input has differed from the output

    // a difference must persist STABLE_CYC cycles before it is accepted
    always @(posedge clk)
    begin
        if (rst)
        begin
            cnt_q <= 4'h0;
            dout  <= 1'b1;   // idle bus lines sit high
        end
        else if (din == dout)
        begin
            cnt_q <= 4'h0;   // short pulse died out, forget it
        end
        else if (cnt_q == STABLE_CYC[3:0] - 4'h1)
        begin
            cnt_q <= 4'h0;
            dout  <= din;
        end
        else
        begin
            cnt_q <= cnt_q + 4'h1;
        end
    end

endmodule // glitch_reject
